// [dv/acr_line_model.sv]
// Line-side model: receive frame events and data register strobes
module acr_line_model (
    // Clock
    input  wire logic  clk,
    // Receive events toward the block
    output logic [1:0] frame_done,
    output logic [1:0] frame_addr_bit,
    output logic [1:0] frame_ovr,
    output logic [1:0] frame_perr,
    output logic [1:0] frame_ferr,
    // Data register strobes
    output logic [1:0] rx_read,
    output logic [1:0] tx_load,
    output logic [1:0] tx_taken
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet line at time zero
    initial begin
        frame_done = 2'h0;
        frame_addr_bit = 2'h0;
        frame_ovr = 2'h0;
        frame_perr = 2'h0;
        frame_ferr = 2'h0;
        rx_read = 2'h0;
        tx_load = 2'h0;
        tx_taken = 2'h0;
    end

    // One received frame, q = {address bit, overrun, parity, framing}
    task automatic frame(input int ch, input logic [3:0] q);
        @(posedge clk);
        frame_done[ch] <= 1'h1;
        {frame_addr_bit[ch], frame_ovr[ch]} <= q[3:2];
        {frame_perr[ch], frame_ferr[ch]} <= q[1:0];
        @(posedge clk);
        frame_done[ch] <= 1'h0;
        // Qualifiers mean nothing after the pulse: show the inverse
        {frame_addr_bit[ch], frame_ovr[ch]} <= ~q[3:2];
        {frame_perr[ch], frame_ferr[ch]} <= ~q[1:0];
    endtask

    // One-cycle strobe: kind 0 data read, 1 data load, 2 byte taken
    task automatic strobe(input int ch, input int kind);
        @(posedge clk);
        rx_read[ch] <= (kind == 0);
        tx_load[ch] <= (kind == 1);
        tx_taken[ch] <= (kind == 2);
        @(posedge clk);
        {rx_read[ch], tx_load[ch], tx_taken[ch]} <= 3'h0;
    endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the control register A block
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Design-side signals
    logic        clk, resetn, ce, io_halt_mode, request_send_out_n;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, chan1_ext_clock_in;
    logic        chan1_ext_clock_out, chan1_ext_clock_oe, chan1_clk_drive;
    logic        chan1_clk_gen, dma_end_pulse, chan1_clk_sampled;
    logic [1:0]  frame_done, frame_addr_bit, frame_ovr, frame_perr;
    logic [1:0]  frame_ferr, rx_read, tx_load, tx_taken;
    logic [1:0]  rx_en, tx_en, data8, parity_on, stop2;
    int          fail_count, samples_checked;

    acr_top dut (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_halt_mode,
        .request_send_out_n, .chan1_ext_clock_in, .chan1_ext_clock_out,
        .chan1_ext_clock_oe, .chan1_clk_drive, .chan1_clk_gen,
        .dma_end_pulse, .chan1_clk_sampled, .frame_done, .frame_addr_bit,
        .frame_ovr, .frame_perr, .frame_ferr, .rx_read, .tx_load,
        .tx_taken, .rx_en, .tx_en, .data8, .parity_on, .stop2);

    acr_line_model line (.clk, .frame_done, .frame_addr_bit, .frame_ovr,
        .frame_perr, .frame_ferr, .rx_read, .tx_load, .tx_taken);

    // 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // A wait ran out of its bound
    task automatic timeout();
        $display("unexpected bus_wait expected answer seen none");
        fail_count++;
        give_verdict();
    endtask

    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [3:0] idx, input logic [7:0] v,
                      input logic [3:0] strb, output logic [1:0] resp);
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = (s_axi_bvalid === 1'h1);
            resp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        timeout();
    endtask

    // Bus read: address held until taken, data taken at the answer edge
    task automatic rd(input logic [3:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        logic a, r;
        @(posedge clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            a = s_axi_arvalid && s_axi_arready;
            r = (s_axi_rvalid === 1'h1);
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
            if (a) s_axi_arvalid <= 1'h0;
            if (r) begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        timeout();
    endtask

    // Full-word write expecting an OKAY response
    task automatic wok(input logic [3:0] idx, input logic [7:0] v);
        logic [1:0] r;
        wr(idx, v, 4'hF, r);
        chk("bresp", {30'h0, acr_pkg::RESP_OKAY}, {30'h0, r});
    endtask

    // Read and compare the masked byte; upper bits must read zero
    task automatic rchk(input string nm, input logic [3:0] idx,
                        input logic [7:0] mask, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(nm, {24'h0, e & mask}, d & {24'hFFFFFF, mask});
    endtask

    task automatic t_reset();
        rchk("ctrl0_reset", 4'h0, 8'hF7, 8'h10);
        rchk("ctrl1_reset", 4'h1, 8'hF7, 8'h00);
        chk("rx_en", 32'h0, {30'h0, rx_en});
        chk("tx_en", 32'h0, {30'h0, tx_en});
        rchk("tx_empty_reset", 4'h4, 8'h02, 8'h02);
        $display("test reset done");
    endtask

    task automatic t_enable();
        wok(4'h0, 8'h78);
        chk("rx_en0", 32'h1, {31'h0, rx_en[0]});
        chk("tx_en0", 32'h1, {31'h0, tx_en[0]});
        chk("rts_pin", 32'h1, {31'h0, request_send_out_n});
        line.strobe(0, 1);
        wok(4'h0, 8'h08);
        chk("rts_pin", 32'h0, {31'h0, request_send_out_n});
        chk("en0", 32'h0, {30'h0, rx_en[0], tx_en[0]});
        rchk("tx_empty_held", 4'h4, 8'h02, 8'h00);
        wok(4'h1, 8'h68);
        chk("en1", 32'h3, {30'h0, rx_en[1], tx_en[1]});
        // Halt overrides the written enables
        @(posedge clk) io_halt_mode <= 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("en_halt", 32'h0, {30'h0, rx_en[1], tx_en[1]});
        @(posedge clk) io_halt_mode <= 1'h0;
        rchk("ctrl1_halt", 4'h1, 8'h60, 8'h00);
        $display("test enable done");
    endtask

    task automatic t_format();
        for (int i = 0; i < 8; i++) begin
            wok(4'h0, {5'h01, 3'(i)});
            chk("fmt", 32'(i), {29'h0, data8[0], parity_on[0], stop2[0]});
            rchk("fmt_read", 4'h0, 8'h07, 8'(i));
        end
        wok(4'h2, 8'h40);
        chk("mp_fmt", 32'h5, {29'h0, data8[0], parity_on[0], stop2[0]});
        wok(4'h2, 8'h00);
        $display("test format done");
    endtask

    task automatic t_flags();
        wok(4'h0, 8'h4A);
        line.frame(0, 4'h7);
        rchk("stat_err", 4'h4, 8'hF0, 8'hF0);
        wok(4'h0, 8'h4A);
        rchk("stat_keep", 4'h4, 8'hF0, 8'hF0);
        wok(4'h0, 8'h42);
        rchk("stat_clear", 4'h4, 8'hF0, 8'h80);
        wok(4'h0, 8'h0A);
        line.frame(0, 4'h7);
        rchk("stat_rx_off", 4'h4, 8'hF0, 8'h80);
        $display("test flags done");
    endtask

    task automatic t_wake();
        wok(4'h3, 8'h40);
        wok(4'h1, 8'hC8);
        line.frame(1, 4'h1);
        rchk("wake_skip", 4'h5, 8'h90, 8'h00);
        line.frame(1, 4'h8);
        rchk("wake_take", 4'h5, 8'h80, 8'h80);
        rchk("addr_bit1", 4'h1, 8'h08, 8'h08);
        line.strobe(1, 0);
        wok(4'h1, 8'h48);
        line.frame(1, 4'h0);
        rchk("nowake_take", 4'h5, 8'h80, 8'h80);
        rchk("addr_bit0", 4'h1, 8'h08, 8'h00);
        line.strobe(1, 0);
        wok(4'h3, 8'h00);
        wok(4'h1, 8'hC8);
        line.frame(1, 4'h0);
        rchk("plain_take", 4'h5, 8'h80, 8'h80);
        $display("test wake done");
    endtask

    task automatic t_pin();
        logic [1:0] r;
        logic [31:0] d;
        wok(4'h1, 8'h10);
        @(posedge clk) dma_end_pulse <= 1'h1;
        @(negedge clk);
        chk("pin_dma", 32'h3, {30'h0, chan1_ext_clock_out, chan1_ext_clock_oe});
        wok(4'h1, 8'h00);
        @(posedge clk) {chan1_clk_drive, chan1_clk_gen} <= 2'h1;
        chan1_ext_clock_in <= 1'h1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("pin_clk", 32'h2, {30'h0, chan1_ext_clock_out, chan1_ext_clock_oe});
        chk("pin_in", 32'h1, {31'h0, chan1_clk_sampled});
        // Unmapped places and an empty strobe
        wr(4'h4, 8'hFF, 4'hF, r);
        chk("bresp_bad", {30'h0, acr_pkg::RESP_SLVERR}, {30'h0, r});
        rd(4'h7, d, r);
        chk("rresp_bad", {30'h0, acr_pkg::RESP_SLVERR}, {30'h0, r});
        chk("rdata_bad", 32'h0, d);
        wr(4'h0, 8'hFF, 4'h0, r);
        rchk("no_strobe", 4'h0, 8'hF7, 8'h0A);
        @(posedge clk) ce <= 1'h0;
        line.strobe(0, 1);
        @(posedge clk) ce <= 1'h1;
        rchk("ce_freeze", 4'h4, 8'h02, 8'h02);
        $display("test pin and bus done");
    endtask

    // Main sequence
    initial begin
        {resetn, ce, io_halt_mode, chan1_ext_clock_in} = 4'h4;
        {chan1_clk_drive, chan1_clk_gen, dma_end_pulse} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 16'h0;
        s_axi_wdata = 32'h0;
        fail_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_reset();
        t_enable();
        t_format();
        t_flags();
        t_wake();
        t_pin();
        give_verdict();
    end
endmodule

// [hw/acr_flags.sv]
// Receive and transmit flag keeping for one serial channel
module acr_flags (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Receive events from the shifter
    input  wire logic frame_done,
    input  wire logic frame_addr_bit,
    input  wire logic frame_ovr,
    input  wire logic frame_perr,
    input  wire logic frame_ferr,
    // Control
    input  wire logic mp_fmt,
    input  wire logic wake_en,
    input  wire logic parity_en,
    input  wire logic err_clear,
    input  wire logic rx_read,
    input  wire logic tx_load,
    input  wire logic tx_taken,
    input  wire logic halt,
    // Flags
    output logic      rx_full_q,
    output logic      ovr_q,
    output logic      perr_q,
    output logic      ferr_q,
    output logic      tx_empty_q,
    output logic      addr_bit_q
);
    logic frame_counts;
    logic par_ok;

    // Wake filter applies only in multiprocessor format
    assign frame_counts = frame_done & (~mp_fmt | ~wake_en | frame_addr_bit);
    assign par_ok       = parity_en & ~mp_fmt;

    // Flags: an event in the clearing cycle wins over the clear; halt wins over the event, except that addr_bit_q still loads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_full_q  <= 1'b0;
            ovr_q      <= 1'b0;
            perr_q     <= 1'b0;
            ferr_q     <= 1'b0;
            tx_empty_q <= 1'b1;
            addr_bit_q <= 1'b0;
        end else if (ce) begin
            if (halt) begin
                rx_full_q  <= 1'b0;
                ovr_q      <= 1'b0;
                perr_q     <= 1'b0;
                ferr_q     <= 1'b0;
                tx_empty_q <= 1'b1;
            end else begin
                rx_full_q  <= frame_counts | (rx_full_q & ~rx_read);
                ovr_q      <= (frame_counts & frame_ovr)
                              | (ovr_q & ~err_clear);
                perr_q     <= (frame_counts & frame_perr & par_ok)
                              | (perr_q & ~err_clear);
                ferr_q     <= (frame_counts & frame_ferr)
                              | (ferr_q & ~err_clear);
                tx_empty_q <= tx_taken | (tx_empty_q & ~tx_load);
            end
            if (frame_done && mp_fmt)
                addr_bit_q <= frame_addr_bit;
        end
    end
endmodule

// [hw/acr_pkg.sv]
// Package: register map, field positions and reset values of control reg A
package acr_pkg;
    localparam int          ADDR_W         = 4;
    // Printed offsets 0x00 and 0x01 are indices; byte address is index * 4
    localparam logic [3:0]  IDX_CTRL_A_CH0 = 4'h0;
    localparam logic [3:0]  IDX_CTRL_A_CH1 = 4'h1;
    localparam logic [3:0]  IDX_CTRL_B_CH0 = 4'h2;
    localparam logic [3:0]  IDX_CTRL_B_CH1 = 4'h3;
    localparam logic [3:0]  IDX_STAT_CH0   = 4'h4;
    localparam logic [3:0]  IDX_STAT_CH1   = 4'h5;
    // Control register A fields
    localparam int          B_WAKE         = 7;
    localparam int          B_RXEN         = 6;
    localparam int          B_TXEN         = 5;
    localparam int          B_PIN4         = 4;
    localparam int          B_MPB_EFC      = 3;
    localparam int          B_DLEN         = 2;
    localparam int          B_PAR          = 1;
    localparam int          B_STOP         = 0;
    // Control register B: only the format select bit lives here
    localparam int          B_MPF          = 6;
    // Status register fields
    localparam int          S_RXFULL       = 7;
    localparam int          S_OVR          = 6;
    localparam int          S_PERR         = 5;
    localparam int          S_FERR         = 4;
    localparam int          S_TXEMPTY      = 1;
    localparam logic [7:0]  RST_CTRL_A_CH0 = 8'h10;
    localparam logic [7:0]  RST_CTRL_A_CH1 = 8'h00;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// [hw/acr_sync.sv]
// Two-stage synchroniser for a pin input
module acr_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Pin and result
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // The first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// [hw/acr_top.sv]
// Control register A block for both serial channels, AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
module acr_top (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // AXI4-Lite write address and data
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System mode and pins
    input  wire logic        io_halt_mode,
    output logic             request_send_out_n,
    input  wire logic        chan1_ext_clock_in,
    output logic             chan1_ext_clock_out,
    output logic             chan1_ext_clock_oe,
    input  wire logic        chan1_clk_drive,
    input  wire logic        chan1_clk_gen,
    input  wire logic        dma_end_pulse,
    output logic             chan1_clk_sampled,
    // Shifter side, per channel (index = channel)
    input  wire logic [1:0]  frame_done,
    input  wire logic [1:0]  frame_addr_bit,
    input  wire logic [1:0]  frame_ovr,
    input  wire logic [1:0]  frame_perr,
    input  wire logic [1:0]  frame_ferr,
    input  wire logic [1:0]  rx_read,
    input  wire logic [1:0]  tx_load,
    input  wire logic [1:0]  tx_taken,
    output logic [1:0]       rx_en,
    output logic [1:0]       tx_en,
    output logic [1:0]       data8,
    output logic [1:0]       parity_on,
    output logic [1:0]       stop2
);
    logic [7:0] ctla_q [2];
    logic [1:0] mpf_q;
    logic       aw_q, w_q, bvalid_q, rvalid_q;
    logic [3:0] aw_idx_q;
    logic [7:0] wd_q;
    logic       wstb_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q, bresp_q;
    logic       wr_fire, rd_fire;
    logic [3:0] ar_idx;
    logic       wr_ok, rd_ok;
    logic [1:0] wr_a, err_clr;
    logic [1:0] rx_full, ovr, perr, ferr, tx_empty, addr_bit;
    logic [7:0] rd_ctla [2];
    logic [7:0] rd_stat [2];
    logic [7:0] rd_val;

    // Write channel capture, either order
    assign s_axi_awready = ~aw_q & ~bvalid_q & ce;
    assign s_axi_wready  = ~w_q & ~bvalid_q & ce;
    assign wr_fire  = aw_q & w_q & ~bvalid_q & ce;
    assign wr_ok    = (aw_idx_q <= acr_pkg::IDX_CTRL_B_CH1);
    assign wr_a[0]  = wr_fire & wstb_q & (aw_idx_q == acr_pkg::IDX_CTRL_A_CH0);
    assign wr_a[1]  = wr_fire & wstb_q & (aw_idx_q == acr_pkg::IDX_CTRL_A_CH1);
    assign err_clr  = wr_a & {2{~wd_q[acr_pkg::B_MPB_EFC]}};

    // Write address/data holding and response
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            aw_idx_q <= 4'h0;
            wd_q     <= 8'h00;
            wstb_q   <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                aw_idx_q <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q    <= 1'b1;
                wd_q   <= s_axi_wdata[7:0];
                wstb_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q & ce;
    assign s_axi_bresp  = bresp_q;

    // Control register A per channel; enables cleared by halt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctla_q[0] <= acr_pkg::RST_CTRL_A_CH0;
            ctla_q[1] <= acr_pkg::RST_CTRL_A_CH1;
            mpf_q     <= 2'h0;
        end else if (ce) begin
            for (int c = 0; c < 2; c++) begin
                if (wr_a[c])
                    ctla_q[c] <= wd_q;
                if (io_halt_mode) begin
                    ctla_q[c][acr_pkg::B_RXEN] <= 1'b0;
                    ctla_q[c][acr_pkg::B_TXEN] <= 1'b0;
                end
            end
            if (wr_fire && wstb_q) begin
                if (aw_idx_q == acr_pkg::IDX_CTRL_B_CH0)
                    mpf_q[0] <= wd_q[acr_pkg::B_MPF];
                if (aw_idx_q == acr_pkg::IDX_CTRL_B_CH1)
                    mpf_q[1] <= wd_q[acr_pkg::B_MPF];
            end
        end
    end

    // Per-channel control outputs
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            assign rx_en[c]     = ctla_q[c][acr_pkg::B_RXEN];
            assign tx_en[c]     = ctla_q[c][acr_pkg::B_TXEN];
            assign data8[c]     = ctla_q[c][acr_pkg::B_DLEN];
            assign stop2[c]     = ctla_q[c][acr_pkg::B_STOP];
            // Multiprocessor format has no parity
            assign parity_on[c] = ctla_q[c][acr_pkg::B_PAR] & ~mpf_q[c];

            acr_flags u_flags (
                .clk            (clk),
                .resetn         (resetn),
                .ce             (ce),
                .frame_done     (frame_done[c] & rx_en[c]),
                .frame_addr_bit (frame_addr_bit[c]),
                .frame_ovr      (frame_ovr[c]),
                .frame_perr     (frame_perr[c]),
                .frame_ferr     (frame_ferr[c]),
                .mp_fmt         (mpf_q[c]),
                .wake_en        (ctla_q[c][acr_pkg::B_WAKE]),
                .parity_en      (ctla_q[c][acr_pkg::B_PAR]),
                .err_clear      (err_clr[c]),
                .rx_read        (rx_read[c]),
                .tx_load        (tx_load[c]),
                .tx_taken       (tx_taken[c] & tx_en[c]),
                .halt           (io_halt_mode),
                .rx_full_q      (rx_full[c]),
                .ovr_q          (ovr[c]),
                .perr_q         (perr[c]),
                .ferr_q         (ferr[c]),
                .tx_empty_q     (tx_empty[c]),
                .addr_bit_q     (addr_bit[c])
            );
            // Bit 3 reads the last address bit; stored write value ignored
            assign rd_ctla[c] = {ctla_q[c][7:4], addr_bit[c],
                                 ctla_q[c][2:0]};
            assign rd_stat[c] = {rx_full[c], ovr[c], perr[c], ferr[c],
                                 2'b00, tx_empty[c], 1'b0};
        end
    endgenerate

    // Channel 0 request-to-send pin, active low
    assign request_send_out_n = ctla_q[0][acr_pkg::B_PIN4];

    // Channel 1 shared pin: external clock or end-of-DMA pulse
    assign chan1_ext_clock_out = ctla_q[1][acr_pkg::B_PIN4] ?
                                 dma_end_pulse : chan1_clk_gen;
    assign chan1_ext_clock_oe  = ctla_q[1][acr_pkg::B_PIN4] |
                                 chan1_clk_drive;

    acr_sync u_ck1 (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .d      (chan1_ext_clock_in),
        .q      (chan1_clk_sampled)
    );

    // Read decode
    assign s_axi_arready = ~rvalid_q & ce;
    assign rd_fire = s_axi_arvalid & ~rvalid_q & ce;
    assign ar_idx  = s_axi_araddr[5:2];
    assign rd_ok   = (ar_idx <= acr_pkg::IDX_STAT_CH1);
    assign rd_val  = (ar_idx == acr_pkg::IDX_CTRL_A_CH0) ? rd_ctla[0] :
                     (ar_idx == acr_pkg::IDX_CTRL_A_CH1) ? rd_ctla[1] :
                     (ar_idx == acr_pkg::IDX_CTRL_B_CH0) ?
                         {1'b0, mpf_q[0], 6'h00} :
                     (ar_idx == acr_pkg::IDX_CTRL_B_CH1) ?
                         {1'b0, mpf_q[1], 6'h00} :
                     (ar_idx == acr_pkg::IDX_STAT_CH0) ? rd_stat[0] :
                     (ar_idx == acr_pkg::IDX_STAT_CH1) ? rd_stat[1] :
                     8'h00;

    // Read response
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (ce) begin
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= {24'h00_0000, rd_val};
                rresp_q  <= rd_ok ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_q & ce;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // Checks
    property p_rx_halt;
        @(posedge clk) disable iff (!resetn)
        (ce && io_halt_mode) |=> !rx_en[0] && !rx_en[1];
    endproperty
    a_rx_halt: assert property (p_rx_halt) else $error("rx enable on in halt");

    property p_tx_halt;
        @(posedge clk) disable iff (!resetn)
        (ce && io_halt_mode) |=> !tx_en[0] && !tx_en[1];
    endproperty
    a_tx_halt: assert property (p_tx_halt) else $error("tx enable on in halt");

    property p_rxen_wr;
        @(posedge clk) disable iff (!resetn)
        (wr_a[0] && !io_halt_mode) |=> rx_en[0] == $past(wd_q[6]);
    endproperty
    a_rxen_wr: assert property (p_rxen_wr) else $error("rx enable not written");

    property p_txen_wr;
        @(posedge clk) disable iff (!resetn)
        (wr_a[1] && !io_halt_mode) |=> tx_en[1] == $past(wd_q[5]);
    endproperty
    a_txen_wr: assert property (p_txen_wr) else $error("tx enable not written");

    property p_rts;
        @(posedge clk) disable iff (!resetn)
        wr_a[0] |=> request_send_out_n == $past(wd_q[4]);
    endproperty
    a_rts: assert property (p_rts) else $error("request pin not following");

    property p_errclr;
        @(posedge clk) disable iff (!resetn)
        (err_clr[0] && !frame_done[0]) |=> !ovr[0] && !ferr[0] && !perr[0];
    endproperty
    a_errclr: assert property (p_errclr) else $error("errors not cleared");

    property p_errkeep;
        @(posedge clk) disable iff (!resetn)
        (ce && wr_a[0] && wd_q[3] && ovr[0] && !io_halt_mode) |=> ovr[0];
    endproperty
    a_errkeep: assert property (p_errkeep) else $error("overrun lost");

    property p_rxfull;
        @(posedge clk) disable iff (!resetn)
        (ce && frame_done[0] && rx_en[0] && !mpf_q[0] && !io_halt_mode)
        |=> rx_full[0];
    endproperty
    a_rxfull: assert property (p_rxfull) else $error("rx full not set");

    property p_dma_pin;
        @(posedge clk) disable iff (!resetn)
        ctla_q[1][4] |-> chan1_ext_clock_oe &&
                         chan1_ext_clock_out == dma_end_pulse;
    endproperty
    a_dma_pin: assert property (p_dma_pin) else $error("pin not dma end");

    property p_rx_off;
        @(posedge clk) disable iff (!resetn)
        (ce && !rx_en[0] && !err_clr[0] && !io_halt_mode)
        |=> $stable({ovr[0], ferr[0], perr[0]});
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("error flags moved");

    property p_tx_off;
        @(posedge clk) disable iff (!resetn)
        (ce && !tx_en[0] && !tx_load[0] && !io_halt_mode)
        |=> $stable(tx_empty[0]);
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("tx empty moved");

    property p_addr_bit;
        @(posedge clk) disable iff (!resetn)
        (ce && frame_done[1] && rx_en[1] && mpf_q[1])
        |=> rd_ctla[1][acr_pkg::B_MPB_EFC] == $past(frame_addr_bit[1]);
    endproperty
    a_addr_bit: assert property (p_addr_bit)
        else $error("address bit not held");

    property p_wake_skip;
        @(posedge clk) disable iff (!resetn)
        (ce && frame_done[1] && mpf_q[1] && ctla_q[1][acr_pkg::B_WAKE] &&
         !frame_addr_bit[1] && !rx_read[1] && !err_clr[1] && !io_halt_mode)
        |=> $stable({rx_full[1], ovr[1], perr[1], ferr[1]});
    endproperty
    a_wake_skip: assert property (p_wake_skip)
        else $error("filtered frame counted");

    property p_wake_off;
        @(posedge clk) disable iff (!resetn)
        (ce && frame_done[1] && rx_en[1] && mpf_q[1] &&
         !ctla_q[1][acr_pkg::B_WAKE] && !io_halt_mode) |=> rx_full[1];
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("frame not counted");

    c_write:  cover property (@(posedge clk) wr_fire);
    c_read:   cover property (@(posedge clk) rd_fire);
    c_filter: cover property (@(posedge clk) frame_done[1] && mpf_q[1]
                              && ctla_q[1][7] && !frame_addr_bit[1]);
endmodule
